// [hdl/gtc_map.svh]
// Purpose: register map and sizes of the timer
// Assumes: included where needed; definitions only
// Notes:   eight words per channel
`ifndef GTC_MAP_SVH
`define GTC_MAP_SVH

// ********
// sizes
// ********
`define GTC_CNT_W        16
`define GTC_NUM_CH       2
`define GTC_CTRL_W       8

// ********
// address layout (word index within a channel, channel bit, top bits)
// ********
`define GTC_WORD_LSB     2
`define GTC_WORD_MSB     4
`define GTC_CH_BIT       5
`define GTC_MAP_TOP_BIT  6
`define GTC_OFS_CTRL     3'h0
`define GTC_OFS_CMD      3'h1
`define GTC_OFS_INIT     3'h2
`define GTC_OFS_DELAY    3'h3
`define GTC_OFS_WIDTH    3'h4
`define GTC_OFS_INTVL    3'h5
`define GTC_OFS_COUNT    3'h6
`define GTC_OFS_STAT     3'h7

// ********
// control, command and status fields
// ********
`define GTC_CTRL_MODE_LSB 0
`define GTC_CTRL_MODE_MSB 2
`define GTC_CTRL_CLK_POL  3
`define GTC_CTRL_GATE_POL 4
`define GTC_CTRL_OUT_POL  5
`define GTC_CTRL_DIR_SW   6
`define GTC_CTRL_DIR_UP   7
`define GTC_CMD_START     0
`define GTC_CMD_RESET     1
`define GTC_STAT_RUN      0
`define GTC_STAT_DONE     1
`define GTC_STAT_OUT      2

// ********
// reset values, and the last timer count of a delay, width or interval
// ********
`define GTC_RST_CTRL     8'h00
`define GTC_RST_CNT      16'h0000
`define GTC_TMR_LAST     16'h0001

`endif

// [hdl/gtc_pkg.sv]
// Purpose: types shared by the general timer block
// Assumes: gtc_map.svh gives the sizes
// Notes:   the whole top state is one packed struct
`include "gtc_map.svh"

package gtc_pkg;

    // one-hot channel states
    typedef enum logic [5:0] {
        GTC_IDLE  = 6'h01,
        GTC_ARMED = 6'h02,
        GTC_MEAS  = 6'h04,
        GTC_DELAY = 6'h08,
        GTC_WIDTH = 6'h10,
        GTC_DONE  = 6'h20
    } gtc_state_e;

    typedef enum logic [2:0] {
        GTC_M_COUNT   = 3'h0,
        GTC_M_PERIOD  = 3'h1,
        GTC_M_PWIDTH  = 3'h2,
        GTC_M_GSINGLE = 3'h3,
        GTC_M_TSINGLE = 3'h4,
        GTC_M_RETRIG  = 3'h5,
        GTC_M_TCONT   = 3'h6,
        GTC_M_GCONT   = 3'h7
    } gtc_mode_e;

    typedef struct packed {
        gtc_state_e                 st;
        logic [`GTC_CTRL_W-1:0]     ctrl;
        logic [`GTC_CNT_W-1:0]      init;
        logic [`GTC_CNT_W-1:0]      dly;
        logic [`GTC_CNT_W-1:0]      wid;
        logic [`GTC_CNT_W-1:0]      itv;
        logic [`GTC_CNT_W-1:0]      cnt;
        logic [`GTC_CNT_W-1:0]      tmr;
        logic                       seen;
        logic                       out;
        logic                       done;
        logic                       pin;
        logic                       clk_prev;
        logic                       gate_prev;
    } gtc_chan_s;

    typedef struct packed {
        gtc_chan_s [`GTC_NUM_CH-1:0] ch;
        logic                        ap_valid;
        logic                        ap_write;
        logic                        ap_ok;
        logic                        ap_chan;
        logic [2:0]                  ap_word;
        logic                        rd_done;
        logic [31:0]                 hrdata;
    } gtc_top_s;

    function automatic gtc_top_s gtc_rst_state();
        gtc_top_s s;
        s = '0;
        for (int i = 0; i < `GTC_NUM_CH; i++) begin
            s.ch[i].st   = GTC_IDLE;
            s.ch[i].ctrl = `GTC_RST_CTRL;
            s.ch[i].cnt  = `GTC_RST_CNT;
        end
        return s;
    endfunction

endpackage

// [hdl/gtc_sync.sv]
// Purpose: two-flop synchroniser for the timer's pin inputs
// Assumes: inputs are asynchronous to mclk_in
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none

module gtc_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gtc_sync_s;

    gtc_sync_s s_q;
    gtc_sync_s s_d;

    always_comb begin
        s_d    = s_q;
        s_d.s1 = async_in;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.s2;

endmodule

`default_nettype wire

// [hdl/gtc_top.sv]
// Purpose: two-channel general timer/counter with eight modes behind an AHB-Lite slave
// Assumes: count clock, gate and direction pins are asynchronous and much slower than mclk_in
// Notes:   register reads take one wait state; writes complete with none
//
// Function
// - eight modes selectable; nothing runs until software issues start
// - software reset clears status, reloads initial count, halts until next start
// - gated count mode starts at initial count, steps once per count edge
// - count readable any time without disturbing counting
// - in modes one, four, eight an inactive gate freezes counting
// - period mode counts clock edges between two successive active gate edges
// - period end drives output active and leaves final count readable
// - pulse-width mode counts while gate active; at its end output active
// - gated single pulse mode emits one pulse after delay, lasting width
// - delay, width and interval are whole count clock periods, timed by it
// - single triggered mode: first gate edge launches one pulse, later ignored
// - retriggered mode: each gate edge launches pulse; edges during pulse ignored
// - triggered continuous mode: first gate edge starts endless interval/width train
// - once that train runs, gate has no effect until next start
// - continuous gated mode: periodic pulses from software start
// - two independent 16-bit up/down counters
// - direction from input pin or software picks increment or decrement
// - count edge, gate level and output polarity each software selectable
`timescale 1ns/1ps
`default_nettype none
`include "gtc_map.svh"

module gtc_top (
    input  wire logic                   mclk_in,
    input  wire logic                   sys_rst_in,
    input  wire logic                   hsel_in,
    input  wire logic [31:0]            haddr_in,
    input  wire logic [1:0]             htrans_in,
    input  wire logic                   hwrite_in,
    input  wire logic [2:0]             hsize_in,
    input  wire logic [31:0]            hwdata_in,
    input  wire logic                   hready_in,
    output logic                        hreadyout_out,
    output logic                        hresp_out,
    output logic      [31:0]            hrdata_out,
    input  wire logic [`GTC_NUM_CH-1:0] count_clock_in,
    input  wire logic [`GTC_NUM_CH-1:0] gate_in,
    input  wire logic [`GTC_NUM_CH-1:0] count_direction_in,
    output logic      [`GTC_NUM_CH-1:0] timer_output_out
);

    localparam int NCH = `GTC_NUM_CH;
    localparam int SW  = 3 * `GTC_NUM_CH;
    localparam gtc_pkg::gtc_top_s RST_STATE = gtc_pkg::gtc_rst_state();

    gtc_pkg::gtc_top_s s_q;
    gtc_pkg::gtc_top_s s_d;

    logic [SW-1:0]  pins_sync;
    logic [NCH-1:0] cclk_s;
    logic [NCH-1:0] gate_s;
    logic [NCH-1:0] dir_s;

    // ********
    // pin synchronisers
    // ********
    // gate and direction are sampled with the count clock, so all three pass the same two stages
    gtc_sync #(
        .W (SW)
    ) u_sync (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({count_direction_in, gate_in, count_clock_in}),
        .sync_out   (pins_sync)
    );

    assign cclk_s = pins_sync[NCH-1:0];
    assign gate_s = pins_sync[2*NCH-1:NCH];
    assign dir_s  = pins_sync[SW-1:2*NCH];

    // ********
    // helpers
    // ********
    function automatic logic [`GTC_CNT_W-1:0] step(input logic [`GTC_CNT_W-1:0] v, input logic up);
        return up ? v + `GTC_CNT_W'(1) : v - `GTC_CNT_W'(1);
    endfunction

    function automatic logic [31:0] rd_word(input gtc_pkg::gtc_chan_s c, input logic [2:0] w);
        logic [31:0] r;
        r = '0;
        case (w)
            `GTC_OFS_CTRL:  r[`GTC_CTRL_W-1:0] = c.ctrl;
            `GTC_OFS_INIT:  r[`GTC_CNT_W-1:0]  = c.init;
            `GTC_OFS_DELAY: r[`GTC_CNT_W-1:0]  = c.dly;
            `GTC_OFS_WIDTH: r[`GTC_CNT_W-1:0]  = c.wid;
            `GTC_OFS_INTVL: r[`GTC_CNT_W-1:0]  = c.itv;
            `GTC_OFS_COUNT: r[`GTC_CNT_W-1:0]  = c.cnt;
            `GTC_OFS_STAT: begin
                r[`GTC_STAT_RUN]  = (c.st != gtc_pkg::GTC_IDLE) && (c.st != gtc_pkg::GTC_DONE);
                r[`GTC_STAT_DONE] = c.done;
                r[`GTC_STAT_OUT]  = c.out;
            end
            default:        r = '0;
        endcase
        return r;
    endfunction

    // ********
    // next state
    // ********
    always_comb begin
        logic                       clk_lvl;
        logic                       clk_edge;
        logic                       gate_act;
        logic                       gate_edge;
        logic                       dir_up;
        logic                       gated;
        logic                       cnt_en;
        logic                       wr;
        logic                       rd_stall;
        logic [`GTC_CTRL_W-1:0]     cr;
        gtc_pkg::gtc_mode_e         mode;
        clk_lvl   = 1'b0;
        clk_edge  = 1'b0;
        gate_act  = 1'b0;
        gate_edge = 1'b0;
        dir_up    = 1'b0;
        gated     = 1'b0;
        cnt_en    = 1'b0;
        wr        = 1'b0;
        cr        = '0;
        mode      = gtc_pkg::GTC_M_COUNT;
        s_d       = s_q;
        rd_stall  = s_q.ap_valid && !s_q.ap_write && !s_q.rd_done;

        for (int i = 0; i < NCH; i++) begin
            cr        = s_q.ch[i].ctrl;
            mode      = gtc_pkg::gtc_mode_e'(cr[`GTC_CTRL_MODE_MSB:`GTC_CTRL_MODE_LSB]);
            clk_lvl   = cclk_s[i] ^ cr[`GTC_CTRL_CLK_POL];
            gate_act  = gate_s[i] ^ cr[`GTC_CTRL_GATE_POL];
            clk_edge  = clk_lvl && !s_q.ch[i].clk_prev;
            gate_edge = gate_act && !s_q.ch[i].gate_prev;
            dir_up    = cr[`GTC_CTRL_DIR_SW] ? cr[`GTC_CTRL_DIR_UP] : dir_s[i];
            gated     = (mode == gtc_pkg::GTC_M_COUNT) || (mode == gtc_pkg::GTC_M_GSINGLE)
                        || (mode == gtc_pkg::GTC_M_GCONT);
            cnt_en    = clk_edge && (gate_act || !gated);
            s_d.ch[i].clk_prev  = clk_lvl;
            s_d.ch[i].gate_prev = gate_act;

            case (s_q.ch[i].st)
                gtc_pkg::GTC_IDLE: begin
                    s_d.ch[i].out = 1'b0;
                end
                gtc_pkg::GTC_MEAS: begin
                    case (mode)
                        gtc_pkg::GTC_M_PERIOD: begin
                            // first gate edge opens the window, the second closes it
                            if (s_q.ch[i].seen && clk_edge) begin
                                s_d.ch[i].cnt = step(s_q.ch[i].cnt, dir_up);
                            end
                            if (gate_edge) begin
                                s_d.ch[i].seen = 1'b1;
                                if (s_q.ch[i].seen) begin
                                    s_d.ch[i].st   = gtc_pkg::GTC_DONE;
                                    s_d.ch[i].out  = 1'b1;
                                    s_d.ch[i].done = 1'b1;
                                end
                            end
                        end
                        gtc_pkg::GTC_M_PWIDTH: begin
                            if (gate_act && clk_edge) begin
                                s_d.ch[i].cnt = step(s_q.ch[i].cnt, dir_up);
                            end
                            if (gate_act) begin
                                s_d.ch[i].seen = 1'b1;
                            end else if (s_q.ch[i].seen) begin
                                s_d.ch[i].st   = gtc_pkg::GTC_DONE;
                                s_d.ch[i].out  = 1'b1;
                                s_d.ch[i].done = 1'b1;
                            end
                        end
                        default: begin
                            if (cnt_en) begin
                                s_d.ch[i].cnt = step(s_q.ch[i].cnt, dir_up);
                            end
                        end
                    endcase
                end
                gtc_pkg::GTC_ARMED: begin
                    // of the pulse states only this one listens to gate edges, so edges during a pulse fall away
                    if (gate_edge) begin
                        s_d.ch[i].st  = gtc_pkg::GTC_DELAY;
                        s_d.ch[i].tmr = s_q.ch[i].dly;
                    end
                end
                gtc_pkg::GTC_DELAY: begin
                    s_d.ch[i].out = 1'b0;
                    if (cnt_en) begin
                        s_d.ch[i].cnt = step(s_q.ch[i].cnt, dir_up);
                        if (s_q.ch[i].tmr <= `GTC_TMR_LAST) begin
                            s_d.ch[i].st  = gtc_pkg::GTC_WIDTH;
                            s_d.ch[i].tmr = s_q.ch[i].wid;
                            s_d.ch[i].out = 1'b1;
                        end else begin
                            s_d.ch[i].tmr = s_q.ch[i].tmr - `GTC_TMR_LAST;
                        end
                    end
                end
                gtc_pkg::GTC_WIDTH: begin
                    if (cnt_en) begin
                        s_d.ch[i].cnt = step(s_q.ch[i].cnt, dir_up);
                        if (s_q.ch[i].tmr <= `GTC_TMR_LAST) begin
                            s_d.ch[i].out = 1'b0;
                            case (mode)
                                gtc_pkg::GTC_M_RETRIG: begin
                                    s_d.ch[i].st = gtc_pkg::GTC_ARMED;
                                end
                                gtc_pkg::GTC_M_TCONT, gtc_pkg::GTC_M_GCONT: begin
                                    s_d.ch[i].st  = gtc_pkg::GTC_DELAY;
                                    s_d.ch[i].tmr = s_q.ch[i].itv;
                                end
                                default: begin
                                    s_d.ch[i].st   = gtc_pkg::GTC_DONE;
                                    s_d.ch[i].done = 1'b1;
                                end
                            endcase
                        end else begin
                            s_d.ch[i].tmr = s_q.ch[i].tmr - `GTC_TMR_LAST;
                        end
                    end
                end
                gtc_pkg::GTC_DONE: begin
                    // pulse modes park with the output inactive, measurement modes hold it active
                    if (mode == gtc_pkg::GTC_M_GSINGLE || mode == gtc_pkg::GTC_M_TSINGLE) begin
                        s_d.ch[i].out = 1'b0;
                    end
                end
                default: begin
                    s_d.ch[i].st = gtc_pkg::GTC_IDLE;
                end
            endcase

            // register writes take the data phase of a write to this channel
            wr = s_q.ap_valid && s_q.ap_write && s_q.ap_ok && (s_q.ap_chan == i[0]);
            if (wr) begin
                case (s_q.ap_word)
                    `GTC_OFS_CTRL:  s_d.ch[i].ctrl = hwdata_in[`GTC_CTRL_W-1:0];
                    `GTC_OFS_INIT:  s_d.ch[i].init = hwdata_in[`GTC_CNT_W-1:0];
                    `GTC_OFS_DELAY: s_d.ch[i].dly  = hwdata_in[`GTC_CNT_W-1:0];
                    `GTC_OFS_WIDTH: s_d.ch[i].wid  = hwdata_in[`GTC_CNT_W-1:0];
                    `GTC_OFS_INTVL: s_d.ch[i].itv  = hwdata_in[`GTC_CNT_W-1:0];
                    default: begin
                    end
                endcase
                if (s_q.ap_word == `GTC_OFS_CMD && hwdata_in[`GTC_CMD_RESET]) begin
                    s_d.ch[i].st   = gtc_pkg::GTC_IDLE;
                    s_d.ch[i].cnt  = s_q.ch[i].init;
                    s_d.ch[i].tmr  = '0;
                    s_d.ch[i].seen = 1'b0;
                    s_d.ch[i].out  = 1'b0;
                    s_d.ch[i].done = 1'b0;
                end
                // start after reset in the same write, so both bits together restart cleanly
                if (s_q.ap_word == `GTC_OFS_CMD && hwdata_in[`GTC_CMD_START]) begin
                    s_d.ch[i].cnt  = s_q.ch[i].init;
                    s_d.ch[i].seen = 1'b0;
                    s_d.ch[i].out  = 1'b0;
                    s_d.ch[i].done = 1'b0;
                    case (mode)
                        gtc_pkg::GTC_M_GSINGLE: begin
                            s_d.ch[i].st  = gtc_pkg::GTC_DELAY;
                            s_d.ch[i].tmr = s_q.ch[i].dly;
                        end
                        gtc_pkg::GTC_M_GCONT: begin
                            s_d.ch[i].st  = gtc_pkg::GTC_DELAY;
                            s_d.ch[i].tmr = s_q.ch[i].itv;
                        end
                        gtc_pkg::GTC_M_TSINGLE, gtc_pkg::GTC_M_RETRIG, gtc_pkg::GTC_M_TCONT: begin
                            s_d.ch[i].st = gtc_pkg::GTC_ARMED;
                        end
                        default: begin
                            s_d.ch[i].st = gtc_pkg::GTC_MEAS;
                        end
                    endcase
                end
            end
            s_d.ch[i].pin = s_d.ch[i].out ^ s_d.ch[i].ctrl[`GTC_CTRL_OUT_POL];
        end

        // ********
        // ahb-lite slave
        // ********
        // read data comes from a flop, which costs one wait state per read
        if (rd_stall) begin
            s_d.hrdata  = s_q.ap_ok ? rd_word(s_q.ch[s_q.ap_chan], s_q.ap_word) : 32'h00000000;
            s_d.rd_done = 1'b1;
        end else begin
            s_d.ap_valid = hsel_in && htrans_in[1] && hready_in;
            s_d.ap_write = hwrite_in;
            s_d.ap_ok    = (haddr_in[31:`GTC_MAP_TOP_BIT] == '0) && (haddr_in[1:0] == 2'h0);
            s_d.ap_chan  = haddr_in[`GTC_CH_BIT];
            s_d.ap_word  = haddr_in[`GTC_WORD_MSB:`GTC_WORD_LSB];
            s_d.rd_done  = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // ********
    // outputs
    // ********
    assign hreadyout_out = !(s_q.ap_valid && !s_q.ap_write && !s_q.rd_done);
    assign hresp_out     = 1'b0;
    assign hrdata_out    = s_q.hrdata;

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_pin
            assign timer_output_out[g] = s_q.ch[g].pin;
        end
    endgenerate

endmodule

`default_nettype wire

// [verif/gtc_pin_model.sv]
// Purpose: far side of the timer pins
// Assumes: changes just after a rising mclk edge
// Notes:   count clock rests low between bursts
`timescale 1ns/1ps
`default_nettype none
`include "gtc_map.svh"
module gtc_pin_model (
    input  wire logic                   mclk_in,
    output logic      [`GTC_NUM_CH-1:0] clk_out,
    output logic      [`GTC_NUM_CH-1:0] gate_out,
    output logic      [`GTC_NUM_CH-1:0] dir_out
);
    // ********
    // pin drivers
    // ********
    int h = 4;
    initial begin
        clk_out = '0;
        gate_out = '0;
        dir_out = '0;
    end
    // each level held h mclk, well over the synchroniser depth
    task automatic pulses(input int c, input int n);
        repeat (n) begin
            @(posedge mclk_in);
            clk_out[c] <= 1'b1;
            repeat (h) @(posedge mclk_in);
            clk_out[c] <= 1'b0;
            repeat (h) @(posedge mclk_in);
        end
    endtask
    // gate and direction settle long before the next count edge
    task automatic set_pin(input int c, input logic g, input logic d);
        @(posedge mclk_in);
        gate_out[c] <= g;
        dir_out[c] <= d;
        repeat (h) @(posedge mclk_in);
    endtask
endmodule
`default_nettype wire

// [verif/gtc_top_bench.sv]
// Purpose: self-checking bench for the general timer top
// Assumes: one bus slave, so hready follows hreadyout
// Notes:   delay, width and interval set to 2, 4 and 2 count edges
`timescale 1ns/1ps
`default_nettype none
`include "gtc_map.svh"
`define GTCB_CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
module gtc_top_bench;
    logic                   mclk_in = 1'b0;
    logic                   sys_rst_in = 1'b1;
    logic                   hsel_in = 1'b0;
    logic [31:0]            haddr_in = '0;
    logic [1:0]             htrans_in = '0;
    logic                   hwrite_in = 1'b0;
    logic [31:0]            hwdata_in = '0;
    logic                   hreadyout_out;
    logic                   hresp_out;
    logic [31:0]            hrdata_out;
    logic [31:0]            rd_q;
    logic [`GTC_NUM_CH-1:0] cclk, gate, dir, tout;
    int                     err_count = 0;
    int                     checked = 0;
    int                     cycles = 0;
    gtc_top dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
        .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .hrdata_out(hrdata_out), .count_clock_in(cclk), .gate_in(gate), .count_direction_in(dir),
        .timer_output_out(tout));
    gtc_pin_model pins (.mclk_in(mclk_in), .clk_out(cclk), .gate_out(gate), .dir_out(dir));
    // ********
    // tasks and scenarios
    // ********
    initial forever #2.5 mclk_in = ~mclk_in;
    task automatic end_of_test();
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic rdy();
        logic r;
        do begin
            @(negedge mclk_in);
            r = hreadyout_out;
            rd_q = hrdata_out;
            @(posedge mclk_in);
        end while (r !== 1'b1);
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in <= a;
        hwrite_in <= w;
        rdy();
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        rdy();
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `GTCB_CHK(rd_q, e)
    endtask
    task automatic edges(input int n, input logic e);
        pins.pulses(0, n);
        `GTCB_CHK(tout[0], e)
    endtask
    task automatic t_regs();
        rdchk(32'h00, 32'h0);
        wr(32'h20, 32'ha5);
        rdchk(32'h20, 32'ha5);
        wr(32'h38, 32'h1234);
        rdchk(32'h38, 32'h0);
        rdchk(32'h24, 32'h0);
        rdchk(32'h40, 32'h0);
        repeat (3) @(posedge mclk_in);
        `GTCB_CHK(tout[1], 1'b1)
        wr(32'h20, 32'h0);
    endtask
    task automatic t_count();
        wr(32'h00, 32'h48);
        wr(32'h08, 32'h5);
        pins.set_pin(0, 1'b1, 1'b1);
        pins.pulses(0, 3);
        rdchk(32'h18, 32'h0);
        wr(32'h04, 32'h1);
        pins.pulses(0, 3);
        rdchk(32'h18, 32'h2);
        pins.set_pin(0, 1'b0, 1'b1);
        pins.pulses(0, 2);
        rdchk(32'h18, 32'h2);
        wr(32'h04, 32'h2);
        pins.set_pin(0, 1'b1, 1'b1);
        pins.pulses(0, 2);
        rdchk(32'h18, 32'h5);
        rdchk(32'h1c, 32'h0);
        wr(32'h00, 32'h0);
        wr(32'h04, 32'h1);
        pins.h = 9;
        pins.pulses(0, 4);
        pins.h = 4;
        rdchk(32'h18, 32'h9);
    endtask
    task automatic t_measure(input logic [31:0] m, input logic [31:0] e);
        wr(32'h20, 32'hc0 | m);
        wr(32'h28, 32'h0);
        pins.set_pin(1, 1'b0, 1'b0);
        wr(32'h24, 32'h1);
        pins.pulses(1, 2);
        pins.set_pin(1, 1'b1, 1'b0);
        pins.pulses(1, 3);
        pins.set_pin(1, 1'b0, 1'b0);
        `GTCB_CHK(tout[1], m == 32'h2)
        pins.pulses(1, 2);
        pins.set_pin(1, 1'b1, 1'b0);
        `GTCB_CHK(tout[1], 1'b1)
        rdchk(32'h38, e);
        rdchk(32'h3c, 32'h6);
    endtask
    task automatic t_pulse(input logic [31:0] m, input logic trig, input logic again);
        pins.set_pin(0, !trig, 1'b0);
        wr(32'h00, m);
        wr(32'h04, 32'h1);
        if (trig) begin
            edges(3, 1'b0);
            pins.set_pin(0, 1'b1, 1'b0);
        end
        edges(1, 1'b0);
        edges(1, 1'b1);
        edges(3, 1'b1);
        edges(1, 1'b0);
        if (trig) begin
            pins.set_pin(0, 1'b0, 1'b0);
            pins.set_pin(0, 1'b1, 1'b0);
        end
        edges(2, again);
    endtask
    initial begin
        repeat (4) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        t_regs();
        t_count();
        t_measure(32'h1, 32'h5);
        t_measure(32'h2, 32'h3);
        wr(32'h0c, 32'h2);
        wr(32'h10, 32'h4);
        wr(32'h14, 32'h2);
        t_pulse(32'h3, 1'b0, 1'b0);
        t_pulse(32'h4, 1'b1, 1'b0);
        t_pulse(32'h5, 1'b1, 1'b1);
        t_pulse(32'h6, 1'b1, 1'b1);
        t_pulse(32'h7, 1'b0, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire

// [verif/gtc_top_checker.sv]
// Purpose: bus and output timing checks on the general timer top
// Assumes: one clock domain, synchronous active high reset
// Notes:   sees only the top ports; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
`include "gtc_map.svh"
module gtc_top_checker (
    input wire logic                   mclk_in,
    input wire logic                   sys_rst_in,
    input wire logic                   hsel_in,
    input wire logic [31:0]            haddr_in,
    input wire logic [1:0]             htrans_in,
    input wire logic                   hwrite_in,
    input wire logic                   hready_in,
    input wire logic                   hreadyout_out,
    input wire logic                   hresp_out,
    input wire logic [31:0]            hrdata_out,
    input wire logic [`GTC_NUM_CH-1:0] count_clock_in,
    input wire logic [`GTC_NUM_CH-1:0] gate_in,
    input wire logic [`GTC_NUM_CH-1:0] timer_output_out
);
    // ********
    // properties
    // ********
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    logic [3:0] quiet_q;
    // cycles with no count clock or gate edge and no bus transfer; the output has no other cause to move
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || $changed(count_clock_in) || $changed(gate_in) || (hsel_in && htrans_in[1] && hready_in))
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hf)
            quiet_q <= quiet_q + 4'h1;
    end
    sequence s_rd_req; hsel_in && htrans_in[1] && hready_in && !hwrite_in; endsequence
    sequence s_wr_req; hsel_in && htrans_in[1] && hready_in && hwrite_in; endsequence
    sequence s_rd_wait; !hreadyout_out ##1 hreadyout_out; endsequence
    a_resp_okay: assert property (hresp_out == 1'b0) else $error("bad response");
    a_read_wait: assert property (s_rd_req |=> s_rd_wait) else $error("read wait wrong");
    a_write_nowait: assert property (s_wr_req |=> hreadyout_out) else $error("write stalled");
    a_rdata_hold: assert property (hreadyout_out |=> $stable(hrdata_out)) else $error("read data moved");
    a_rd_zero: assert property (s_rd_req ##0 (haddr_in[31:6] != 26'h0 || haddr_in[4:0] == 5'h04)
        |=> s_rd_wait ##0 hrdata_out == 32'h0) else $error("empty place read nonzero");
    a_rd_upper: assert property (s_rd_req |=> ##1 hrdata_out[31:16] == 16'h0) else $error("upper bits");
    a_quiet_out: assert property (quiet_q > 4'h8 |=> $stable(timer_output_out)) else $error("output moved");
    a_reset_out: assert property ($fell(sys_rst_in) |-> timer_output_out == '0 && hreadyout_out)
        else $error("reset state wrong");
endmodule
bind gtc_top gtc_top_checker chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out),
    .count_clock_in(count_clock_in), .gate_in(gate_in), .timer_output_out(timer_output_out));
`default_nettype wire
